// ===== hdl/cfg_port_access.sv
// configuration port key decoder, index and data ports
// Notes on behaviour
// - after bus or power-on reset: run state; logical devices disabled only while reset is active
// - data port decodes only in configuration state; index port takes writes in either state, reads only in configuration state
// - strap sampled at bus reset falling edge or power-on reset
// - strap low selects port 0x02E, strap high selects 0x04E
// - software may replace port base via low and high address registers
// - writing 0x55 to config port enters configuration state
// - strap shares pin with general purpose signal, used only at reset
// - writing 0xAA to config port returns to run state
// - index port at config address, data port at next address
// - index 0x07 plus data selects logical device for later accesses
// - global registers reachable without selecting a logical device
`timescale 1ns/100ps
`include "cfg_port_defines.svh"
module cfg_port_access
  import cfg_port_pkg::*;
#(
  parameter int ADDR_W = `CFG_ADDR_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic host_bus_reset_n,
  input wire logic general_pin_twenty_four,
  input wire io_req_s io_req,
  input wire logic [7:0] reg_rdata,
  output io_rsp_s io_rsp,
  output reg_req_s reg_req,
  output logic config_mode,
  output logic [ADDR_W-1:0] port_base,
  output logic devices_enabled_n
);
  ////////////////////////////////////////////////////////////////////
  logic strap_level;
  logic reset_active;
  logic reset_fall;
  cfg_state_e state_reg;
  logic [7:0] port_addr_low_reg;
  logic [7:0] port_addr_high_reg;
  logic [7:0] index_reg;
  logic [7:0] ldn_reg;
  logic [ADDR_W-1:0] base;
  logic hit_cfg;
  logic hit_data;
  logic data_wr;
  logic data_rd;

  strap_sampler u_strap (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .strap_pin(general_pin_twenty_four),
    .host_bus_reset_n(host_bus_reset_n),
    .strap_level(strap_level),
    .reset_active(reset_active),
    .reset_fall(reset_fall)
  );

  ////////////////////////////////////////////////////////////////////
  // address decode
  always_comb begin
    base = ADDR_W'({port_addr_high_reg, port_addr_low_reg});
    hit_cfg = io_req.valid && (io_req.addr[ADDR_W-1:0] == base);
    hit_data = io_req.valid && (state_reg == st_config)
      && (io_req.addr[ADDR_W-1:0] == base + ADDR_W'(`CFG_DATA_OFFSET));
    data_wr = hit_data && io_req.write;
    data_rd = hit_data && !io_req.write;
  end

  ////////////////////////////////////////////////////////////////////
  // run / configuration state
  always_ff @(posedge clk) begin
    if (reset_active) begin
      state_reg <= st_run;
    end else if (clk_en && hit_cfg && io_req.write) begin
      case (state_reg)
        st_run: if (io_req.wdata == `CFG_KEY_ENTER) state_reg <= st_config;
        st_config: if (io_req.wdata == `CFG_KEY_EXIT) state_reg <= st_run;
        default: state_reg <= st_run;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // index port: in config state, writes to config address other than exit key
  always_ff @(posedge clk) begin
    if (reset_active) begin
      index_reg <= `CFG_ZERO_BYTE;
    end else if (clk_en && hit_cfg && io_req.write && state_reg == st_config
                 && io_req.wdata != `CFG_KEY_EXIT) begin
      index_reg <= io_req.wdata;
    end
  end

  // logical device number
  always_ff @(posedge clk) begin
    if (reset_active) begin
      ldn_reg <= `CFG_LDN_RESET;
    end else if (clk_en && data_wr && index_reg == `CFG_IDX_LDN) begin
      ldn_reg <= io_req.wdata;
    end
  end

  // port base registers, reloaded from strap at reset
  always_ff @(posedge clk) begin
    if (sys_rst || reset_fall) begin
      port_addr_low_reg <= strap_level ? 8'(`CFG_BASE_STRAP_HIGH) : 8'(`CFG_BASE_STRAP_LOW);
      port_addr_high_reg <= `CFG_ZERO_BYTE;
    end else if (clk_en && data_wr && index_reg == `CFG_IDX_ADDR_LOW) begin
      port_addr_low_reg <= io_req.wdata;
    end else if (clk_en && data_wr && index_reg == `CFG_IDX_ADDR_HIGH) begin
      port_addr_high_reg <= io_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clk) begin
    if (reset_active) begin
      io_rsp <= '0;
      reg_req <= '0;
      config_mode <= 1'b0;
      devices_enabled_n <= 1'b1;
    end else if (clk_en) begin
      config_mode <= (state_reg == st_config);
      devices_enabled_n <= 1'b0;
      io_rsp.hit <= hit_data || (hit_cfg && (io_req.write || state_reg == st_config));
      // config port is write-only in run state; index port readable in config state
      if (hit_cfg && !io_req.write && state_reg == st_config) io_rsp.rdata <= index_reg;
      else if (data_rd && index_reg == `CFG_IDX_LDN) io_rsp.rdata <= ldn_reg;
      else if (data_rd && index_reg == `CFG_IDX_ADDR_LOW) io_rsp.rdata <= port_addr_low_reg;
      else if (data_rd && index_reg == `CFG_IDX_ADDR_HIGH) io_rsp.rdata <= port_addr_high_reg;
      else if (data_rd) io_rsp.rdata <= reg_rdata;
      else io_rsp.rdata <= `CFG_ZERO_BYTE;
      reg_req.valid <= hit_data;
      reg_req.write <= io_req.write;
      reg_req.global_sel <= (index_reg <= `CFG_IDX_GLOBAL_LAST);
      reg_req.ldn <= ldn_reg;
      reg_req.index <= index_reg;
      reg_req.wdata <= io_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) port_base <= '0;
    else if (clk_en) port_base <= base;
  end
endmodule // cfg_port_access

// ===== hdl/cfg_port_defines.svh
// constants for the configuration port front end
`ifndef CFG_PORT_DEFINES_SVH
`define CFG_PORT_DEFINES_SVH
`define CFG_ADDR_W 16
`define CFG_DATA_W 8
`define CFG_BASE_STRAP_LOW 16'h002E
`define CFG_BASE_STRAP_HIGH 16'h004E
`define CFG_KEY_ENTER 8'h55
`define CFG_KEY_EXIT 8'hAA
`define CFG_DATA_OFFSET 16'h0001
`define CFG_IDX_LDN 8'h07
`define CFG_IDX_ADDR_LOW 8'h26
`define CFG_IDX_ADDR_HIGH 8'h27
`define CFG_IDX_GLOBAL_LAST 8'h2F
`define CFG_LDN_RESET 8'h00
`define CFG_ZERO_BYTE 8'h00
`endif

// ===== hdl/cfg_port_pkg.sv
// types for the configuration port front end
package cfg_port_pkg;
  typedef enum logic {st_run, st_config} cfg_state_e;
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } io_req_s;
  typedef struct packed {
    logic hit;
    logic [7:0] rdata;
  } io_rsp_s;
  typedef struct packed {
    logic valid;
    logic write;
    logic global_sel;
    logic [7:0] ldn;
    logic [7:0] index;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

// ===== hdl/strap_sampler.sv
// strap synchroniser and capture at power-on reset or bus reset falling edge
`timescale 1ns/100ps
`include "cfg_port_defines.svh"
module strap_sampler (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic strap_pin,
  input wire logic host_bus_reset_n,
  output logic strap_level,
  output logic reset_active,
  output logic reset_fall
);
  logic [1:0] strap_sync_reg;
  logic [1:0] rst_sync_reg;
  logic rst_prev_reg;
  logic strap_hold_reg;

  // strap keeps synchronising through power-on reset so its level is known there
  always_ff @(posedge clk) begin
    if (clk_en) begin
      strap_sync_reg <= {strap_sync_reg[0], strap_pin};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_sync_reg <= 2'h0;
      rst_prev_reg <= 1'b0;
    end else if (clk_en) begin
      rst_sync_reg <= {rst_sync_reg[0], host_bus_reset_n};
      rst_prev_reg <= rst_sync_reg[1];
    end
  end

  // level caught at power-on reset or the falling edge of the bus reset; held otherwise
  always_ff @(posedge clk) begin
    if (sys_rst || (clk_en && reset_fall)) begin
      strap_hold_reg <= strap_sync_reg[1];
    end
  end

  always_comb begin
    reset_active = sys_rst || !rst_sync_reg[1];
    reset_fall = rst_prev_reg && !rst_sync_reg[1];
    // at either reset take the live synchronised level
    strap_level = (sys_rst || reset_fall) ? strap_sync_reg[1] : strap_hold_reg;
  end
endmodule // strap_sampler

// ===== sim/cfg_port_chk.sv
// assertions on the configuration port front end
`timescale 1ns/100ps
module cfg_port_chk
  import cfg_port_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic host_bus_reset_n,
  input wire logic general_pin_twenty_four,
  input wire io_req_s io_req,
  input wire logic [7:0] reg_rdata,
  input wire io_rsp_s io_rsp,
  input wire reg_req_s reg_req,
  input wire logic config_mode,
  input wire logic [ADDR_W-1:0] port_base,
  input wire logic devices_enabled_n
);
  logic cp;
  logic dp;
  assign cp = io_req.valid && clk_en && io_req.addr == port_base;
  assign dp = io_req.valid && clk_en && io_req.addr == port_base + 1'b1;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////
  property p_rst;
    disable iff (1'b0) sys_rst |=> !config_mode && !io_rsp.hit && devices_enabled_n;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_enter;
    cp && io_req.write && io_req.wdata == 8'h55 && !config_mode |=> io_rsp.hit ##1 config_mode;
  endproperty
  a_enter: assert property (p_enter) else $error("entry key ignored");
  property p_exit;
    cp && io_req.write && io_req.wdata == 8'hAA |=> ##1 !config_mode;
  endproperty
  a_exit: assert property (p_exit) else $error("exit key ignored");
  property p_data;
    dp |=> io_rsp.hit == config_mode;
  endproperty
  a_data: assert property (p_data) else $error("data port decode wrong");
  property p_cread;
    cp && !io_req.write |=> io_rsp.hit == config_mode;
  endproperty
  a_cread: assert property (p_cread) else $error("config port read claimed");
  property p_key;
    cp && io_req.write && io_req.wdata != 8'h55 ##1 !config_mode |=> !config_mode;
  endproperty
  a_key: assert property (p_key) else $error("wrong key changed state");
  property p_rreq;
    dp && io_req.write |=> reg_req.valid == config_mode &&
      (!config_mode || reg_req.wdata == $past(io_req.wdata));
  endproperty
  a_rreq: assert property (p_rreq) else $error("register request wrong");
  property p_glob;
    reg_req.valid |-> reg_req.global_sel == (reg_req.index <= 8'h2F);
  endproperty
  a_glob: assert property (p_glob) else $error("global flag wrong");
endmodule // cfg_port_chk
bind cfg_port_access cfg_port_chk #(.ADDR_W(ADDR_W)) i_cfg_port_chk (.*);

// ===== sim/host_model.sv
// host chipset model issuing one-cycle I/O accesses
`timescale 1ns/100ps
module host_model
  import cfg_port_pkg::*;
(
  input wire logic clk,
  output io_req_s io_req
);
  initial io_req = '0;
  task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_req = '{1'b1, wr, a, d};
    @(negedge clk);
    io_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule // host_model

// ===== sim/test_cfg_port_access.sv
// self-checking bench for the configuration port front end
`timescale 1ns/100ps
module test_cfg_port_access
  import cfg_port_pkg::*;
;
  logic clk = 0, sys_rst = 1, hbr_n = 1, strap = 0;
  io_req_s io_req;
  io_rsp_s io_rsp;
  reg_req_s reg_req;
  logic config_mode, devices_enabled_n;
  logic [15:0] port_base;
  int num_errors = 0, cmp_count = 0;
  initial forever #2.5 clk = ~clk;
  host_model i_host_model (.clk(clk), .io_req(io_req));
  cfg_port_access i_cfg_port_access (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .host_bus_reset_n(hbr_n), .general_pin_twenty_four(strap), .io_req(io_req),
    .reg_rdata(8'hC3), .io_rsp(io_rsp), .reg_req(reg_req), .config_mode(config_mode),
    .port_base(port_base), .devices_enabled_n(devices_enabled_n));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
    i_host_model.access(wr, a, d);
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_sys_reset(input logic lvl, input logic [15:0] base);
    @(negedge clk);
    strap = lvl;
    sys_rst = 1;
    repeat (10) @(negedge clk);
    chk("dev_off", devices_enabled_n, 1'b1);
    sys_rst = 0;
    repeat (4) @(negedge clk);
    chk("run_state", config_mode, 1'b0);
    chk("base", port_base, base);
    strap = ~lvl;
    repeat (4) @(negedge clk);
    chk("base_hold", port_base, base);
  endtask
  task automatic t_run;
    io(1, 16'h002F, 8'h12);
    chk("run_data", io_rsp.hit, 1'b0);
    io(1, 16'h002E, 8'h11);
    io(0, 16'h002E, 8'h00);
    chk("cfg_read", io_rsp.hit, 1'b0);
    chk("no_key", config_mode, 1'b0);
  endtask
  task automatic t_config;
    io(1, 16'h002E, 8'h55);
    chk("enter", io_rsp.hit, 1'b1);
    io(1, 16'h002E, 8'h07);
    chk("cfg_on", config_mode, 1'b1);
    io(1, 16'h002F, 8'h08);
    chk("req_v", reg_req.valid, 1'b1);
    chk("ldn_idx", reg_req.index, 8'h07);
    chk("ldn_glob", reg_req.global_sel, 1'b1);
    io(1, 16'h002E, 8'hE0);
    io(1, 16'h002F, 8'h02);
    chk("ldn", reg_req.ldn, 8'h08);
    chk("dev_glob", reg_req.global_sel, 1'b0);
    io(0, 16'h002F, 8'h00);
    chk("rdata", io_rsp.rdata, 8'hC3);
    io(0, 16'h002E, 8'h00);
    chk("idx_rd", io_rsp.rdata, 8'hE0);
    io(1, 16'h002E, 8'hAA);
    io(1, 16'h002F, 8'h33);
    chk("exit", io_rsp.hit, 1'b0);
  endtask
  task automatic t_relocate;
    io(1, 16'h002E, 8'h55);
    io(1, 16'h002E, 8'h26);
    io(1, 16'h002F, 8'h60);
    io(1, 16'h0060, 8'h27);
    io(1, 16'h0061, 8'h01);
    @(negedge clk);
    chk("new_base", port_base, 16'h0160);
    io(1, 16'h0160, 8'hAA);
    io(1, 16'h0161, 8'h00);
    chk("new_exit", io_rsp.hit, 1'b0);
    hbr_n = 0;
    repeat (8) @(negedge clk);
    chk("bus_rst_base", port_base, 16'h004E);
    chk("bus_rst_dev", devices_enabled_n, 1'b1);
    hbr_n = 1;
    repeat (4) @(negedge clk);
    io(1, 16'h004E, 8'h55);
    chk("strap_enter", io_rsp.hit, 1'b1);
  endtask
  initial begin
    t_sys_reset(0, 16'h002E);
    t_run();
    t_config();
    t_relocate();
    t_sys_reset(1, 16'h004E);
    report_and_stop();
  end
  initial begin
    #20000;
    num_errors++;
    report_and_stop();
  end
endmodule // test_cfg_port_access
